// [hw/cffc_consts.vh]
// Shared constants for the flag and program-flow execution unit
// ****************************************************************
// Behaviour
// - Only carry, irq mask, overflow have set/clear
// - Accumulator A and flag register transfer both ways
// - Stop-disable changes only through A-to-flags transfer
// - Stop-disable set locks out the stop function
// - Software never raises the nonmaskable mask bit
// - Half-carry never used as a branch condition
// - Simple branches test one flag, either sense
// - Signed and unsigned compares; unsigned ge/lt alias carry
// - Bit-test branches use direct, X or Y addressing
// - Branch reach is -128 to +127 locations
// - Every branch condition has an opposite branch
// - Jump reaches all 64k via four modes
// - Calls push resume address, return pulls it
// - Software interrupt stacks all working registers
// - Wait holds standby until an interrupt arrives
// - Wait stacks first; interrupt then fetches vector
// - Stop with stop-disable set acts as no-op
// - Stack pointer addresses the next free byte
// ****************************************************************
`ifndef CFFC_CONSTS_VH
`define CFFC_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CFFC_OFS_INSTR   8'h00
`define CFFC_OFS_OPND    8'h04
`define CFFC_OFS_PC      8'h08
`define CFFC_OFS_SP      8'h0c
`define CFFC_OFS_FLAGS   8'h10
`define CFFC_OFS_ACC     8'h14
`define CFFC_OFS_IDX     8'h18
`define CFFC_OFS_STATUS  8'h1c

// ****************************************************************
// Flag register bit positions and reset value
// ****************************************************************
`define CFFC_FL_S        7
`define CFFC_FL_X        6
`define CFFC_FL_H        5
`define CFFC_FL_I        4
`define CFFC_FL_N        3
`define CFFC_FL_Z        2
`define CFFC_FL_V        1
`define CFFC_FL_C        0
`define CFFC_FLAGS_RST   8'hd0
`define CFFC_SP_RST      16'h00ff

// ****************************************************************
// Operation codes held in the instruction register
// ****************************************************************
`define CFFC_OP_NOP      5'h00
`define CFFC_OP_CCLR     5'h01
`define CFFC_OP_CSET     5'h02
`define CFFC_OP_ICLR     5'h03
`define CFFC_OP_SEI      5'h04
`define CFFC_OP_VCLR     5'h05
`define CFFC_OP_VSET     5'h06
`define CFFC_OP_TAP      5'h07
`define CFFC_OP_FTOA     5'h08
`define CFFC_OP_BR       5'h09
`define CFFC_OP_BTCLR    5'h0a
`define CFFC_OP_BTSET    5'h0b
`define CFFC_OP_JUMP     5'h0c
`define CFFC_OP_CALL     5'h0d
`define CFFC_OP_RCALL    5'h0e
`define CFFC_OP_RTS      5'h0f
`define CFFC_OP_IRET     5'h10
`define CFFC_OP_SINT     5'h11
`define CFFC_OP_WAIT     5'h12
`define CFFC_OP_STOP     5'h13

// ****************************************************************
// Addressing modes and vectors
// ****************************************************************
`define CFFC_MD_DIR      2'h0
`define CFFC_MD_EXT      2'h1
`define CFFC_MD_INDX     2'h2
`define CFFC_MD_INDY     2'h3
`define CFFC_VEC_SINT    16'hfff6
`define CFFC_VEC_NMI     16'hfff4
`define CFFC_VEC_IRQ     16'hfff2
`define CFFC_STK_ALL     4'h8
`define CFFC_STK_RET     4'h1

`endif

// [hw/cffc_cond.v]
// Branch condition evaluator for the relative branch group
`timescale 1ns/1ps
module cffc_cond (
	// Branch selector
	input  wire [3:0] cond,
	// Flags; half-carry is deliberately not an input
	input  wire       flag_n,
	input  wire       flag_z,
	input  wire       flag_v,
	input  wire       flag_c,
	// Result
	output wire       taken
);

	reg base;	// Sense of the even selector of each pair

	// ************************************************************
	// Condition table
	// ************************************************************
	// Even selectors hold the base test, odd ones its opposite
	always @* begin
		case (cond[3:1])
			3'h0: base = 1'b1;			// Always
			3'h1: base = ~(flag_c | flag_z);	// Higher
			3'h2: base = ~flag_c;			// Carry clear
			3'h3: base = ~flag_z;			// Not equal
			3'h4: base = ~flag_v;			// Overflow clear
			3'h5: base = ~flag_n;			// Plus
			3'h6: base = ~(flag_n ^ flag_v);	// Signed ge
			3'h7: base = ~(flag_z | (flag_n ^ flag_v)); // Signed gt
			default: base = 1'b0;
		endcase
	end

	// Low bit flips the sense, giving each branch its opposite
	assign taken = base ^ cond[0];

endmodule // cffc_cond

// [hw/cffc_core.v]
// Flag and program-flow execution unit with an AXI4-Lite port
`timescale 1ns/1ps
`include "cffc_consts.vh"
module cffc_core #(
	parameter [15:0] SP_RESET = `CFFC_SP_RST
) (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// Program memory and stack
	output wire [15:0] mem_addr,
	output wire [7:0]  mem_wdata,
	output wire        mem_we,
	output wire        mem_re,
	input  wire [7:0]  mem_rdata,
	// Interrupt inputs
	input  wire        irq_in,
	input  wire        nonmaskable_irq_input_n,
	// Power state
	output wire        wait_mode,
	output wire        stop_mode
);

	// ************************************************************
	// Sequencer states
	// ************************************************************
	localparam [3:0] ST_IDLE  = 4'h0;	// Ready for an instruction
	localparam [3:0] ST_READ  = 4'h1;	// Bit-test operand read
	localparam [3:0] ST_PUSH  = 4'h2;	// Stacking bytes
	localparam [3:0] ST_PULLA = 4'h3;	// Pull or vector address
	localparam [3:0] ST_PULLD = 4'h4;	// Pull or vector data
	localparam [3:0] ST_WAIT  = 4'h5;	// Standby, registers stacked
	localparam [3:0] ST_STOP  = 4'h6;	// Clocks notionally frozen

	// ************************************************************
	// Storage
	// ************************************************************
	reg  [3:0]  state_q;	// Sequencer state
	reg         start_q;	// Instruction written, not yet run
	reg  [11:0] instr_q;	// Cond, mode and operation
	reg  [31:0] opnd_q;	// Rel, mask and operand
	reg  [15:0] pc_q;	// Address of the following instruction
	reg  [15:0] sp_q;	// Next free stack byte
	reg  [7:0]  flags_q;	// Flag register
	reg  [7:0]  acc_a_q;	// Accumulator A
	reg  [7:0]  acc_b_q;	// Accumulator B
	reg  [15:0] idx_x_q;	// Index X
	reg  [15:0] idx_y_q;	// Index Y
	reg  [15:0] tgt_q;	// Call destination
	reg  [15:0] vaddr_q;	// Vector being fetched
	reg         vec_q;	// Pull engine is fetching a vector
	reg  [3:0]  cnt_q;	// Byte index on the stack frame
	reg  [3:0]  last_q;	// Last push index
	reg         taken_q;	// Last branch went to its target
	reg         illegal_q;	// Last operation code was undefined
	reg  [15:0] maddr_q;	// Memory address
	reg  [7:0]  mwdata_q;	// Memory write byte
	reg         mwe_q;	// Memory write strobe
	reg         mre_q;	// Memory read strobe
	// AXI holding registers
	reg         aw_full_q;
	reg  [7:0]  aw_addr_q;
	reg         w_full_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         bvalid_q;
	reg  [1:0]  bresp_q;
	reg         rvalid_q;
	reg  [31:0] rdata_q;
	reg  [1:0]  rresp_q;

	// ************************************************************
	// Decode of the held instruction
	// ************************************************************
	wire [4:0]  op    = instr_q[4:0];
	wire [1:0]  mode  = instr_q[6:5];
	wire [3:0]  cond  = instr_q[11:8];
	wire        bit_op = (op == `CFFC_OP_BTCLR) ||
			     (op == `CFFC_OP_BTSET);
	// Offset byte: bit tests carry it apart from the address
	wire [7:0]  rel   = bit_op ? opnd_q[31:24] : opnd_q[7:0];
	// Sign-extended offset, so reach is -128..+127
	wire [15:0] rel_tgt = pc_q + {{8{rel[7]}}, rel};
	wire        cond_taken;	// Branch test result
	wire        busy;	// Instruction under way
	wire        irq_pend;	// Maskable request seen
	wire        nmi_pend;	// Nonmaskable request seen
	wire        do_wr;	// Write address and data both held
	wire        wr_ok;	// Register write may land
	wire [31:0] wmask;	// Byte lanes from strobes
	reg  [15:0] ea;	// Effective address
	reg  [7:0]  push_byte;	// Byte at the current frame index
	reg         rd_hit;	// Read address is mapped
	reg  [31:0] rd_val;	// Read value
	reg         wr_hit;	// Write address is mapped
	reg  [7:0]  tst;	// Bit-test result byte

	// Effective address by addressing mode
	always @* begin
		case (mode)
			`CFFC_MD_DIR:  ea = {8'h00, opnd_q[7:0]};
			`CFFC_MD_EXT:  ea = opnd_q[15:0];
			`CFFC_MD_INDX: ea = idx_x_q + {8'h00, opnd_q[7:0]};
			`CFFC_MD_INDY: ea = idx_y_q + {8'h00, opnd_q[7:0]};
			default:       ea = opnd_q[15:0];
		endcase
	end

	// Frame layout: return address lowest index, flags last
	always @* begin
		case (cnt_q)
			4'h0:    push_byte = pc_q[7:0];
			4'h1:    push_byte = pc_q[15:8];
			4'h2:    push_byte = idx_y_q[7:0];
			4'h3:    push_byte = idx_y_q[15:8];
			4'h4:    push_byte = idx_x_q[7:0];
			4'h5:    push_byte = idx_x_q[15:8];
			4'h6:    push_byte = acc_a_q;
			4'h7:    push_byte = acc_b_q;
			default: push_byte = flags_q;
		endcase
	end

	// Bit test: clear-test looks at ones, set-test at zeros
	always @* begin
		if (op == `CFFC_OP_BTCLR)
			tst = mem_rdata & opnd_q[23:16];
		else
			tst = ~mem_rdata & opnd_q[23:16];
	end

	// Branch condition table sees N, Z, V and C only
	cffc_cond u_cond (
		.cond   (cond),
		.flag_n (flags_q[`CFFC_FL_N]),
		.flag_z (flags_q[`CFFC_FL_Z]),
		.flag_v (flags_q[`CFFC_FL_V]),
		.flag_c (flags_q[`CFFC_FL_C]),
		.taken  (cond_taken)
	);

	assign busy      = (state_q != ST_IDLE) | start_q;
	assign irq_pend  = irq_in & ~flags_q[`CFFC_FL_I];
	assign nmi_pend  = ~nonmaskable_irq_input_n & ~flags_q[`CFFC_FL_X];

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	assign s_axi_awready = ~aw_full_q;
	assign s_axi_wready  = ~w_full_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
	// Writes while busy are answered but dropped, so software
	// cannot tear the machine state in the middle of a frame
	assign wr_ok = do_wr & ~busy;
	assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
			{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	// Write address decode; the flag register has no write path
	always @* begin
		case (aw_addr_q)
			`CFFC_OFS_INSTR, `CFFC_OFS_OPND, `CFFC_OFS_PC,
			`CFFC_OFS_SP, `CFFC_OFS_ACC, `CFFC_OFS_IDX:
				wr_hit = 1'b1;
			`CFFC_OFS_FLAGS, `CFFC_OFS_STATUS:
				wr_hit = 1'b1;	// Read-only, write ignored
			default: wr_hit = 1'b0;
		endcase
	end

	// Read multiplexer
	always @* begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`CFFC_OFS_INSTR:  rd_val = {20'h00000, instr_q};
			`CFFC_OFS_OPND:   rd_val = opnd_q;
			`CFFC_OFS_PC:     rd_val = {16'h0000, pc_q};
			`CFFC_OFS_SP:     rd_val = {16'h0000, sp_q};
			`CFFC_OFS_FLAGS:  rd_val = {24'h000000, flags_q};
			`CFFC_OFS_ACC:    rd_val = {16'h0000, acc_b_q, acc_a_q};
			`CFFC_OFS_IDX:    rd_val = {idx_y_q, idx_x_q};
			`CFFC_OFS_STATUS: rd_val = {27'h0000000, illegal_q,
				taken_q, stop_mode, wait_mode, busy};
			default: begin
				rd_val = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Channel holding registers and responses
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= 2'h0;
		end else begin
			// Address and data are taken in either order
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			// Response follows both halves
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? 2'h0 : 2'h2;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			// Read answers one cycle after the address
			if (s_axi_arvalid && !rvalid_q) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_val;
				rresp_q  <= rd_hit ? 2'h0 : 2'h2;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Execution sequencer
	// ************************************************************
	// Owns every CPU register; software writes enter here too
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= ST_IDLE;
			start_q   <= 1'b0;
			instr_q   <= 12'h000;
			opnd_q    <= 32'h00000000;
			pc_q      <= 16'h0000;
			sp_q      <= SP_RESET;
			flags_q   <= `CFFC_FLAGS_RST;
			acc_a_q   <= 8'h00;
			acc_b_q   <= 8'h00;
			idx_x_q   <= 16'h0000;
			idx_y_q   <= 16'h0000;
			tgt_q     <= 16'h0000;
			vaddr_q   <= 16'h0000;
			vec_q     <= 1'b0;
			cnt_q     <= 4'h0;
			last_q    <= 4'h0;
			taken_q   <= 1'b0;
			illegal_q <= 1'b0;
			maddr_q   <= 16'h0000;
			mwdata_q  <= 8'h00;
			mwe_q     <= 1'b0;
			mre_q     <= 1'b0;
		end else begin
			// Strobes are single-cycle unless renewed below
			mwe_q <= 1'b0;
			mre_q <= 1'b0;
			// Software register writes, honoured only when idle
			if (wr_ok) begin
				case (aw_addr_q)
				`CFFC_OFS_INSTR: begin
					instr_q <= {w_strb_q[1] ? w_data_q[11:8] :
						instr_q[11:8], w_strb_q[0] ?
						{1'b0, w_data_q[6:0]} : instr_q[7:0]};
					start_q <= 1'b1;
				end
				`CFFC_OFS_OPND:
					opnd_q <= (opnd_q & ~wmask) |
						(w_data_q & wmask);
				`CFFC_OFS_PC: begin
					pc_q[7:0] <= w_strb_q[0] ?
						w_data_q[7:0] : pc_q[7:0];
					pc_q[15:8] <= w_strb_q[1] ?
						w_data_q[15:8] : pc_q[15:8];
				end
				`CFFC_OFS_SP: begin
					sp_q[7:0] <= w_strb_q[0] ?
						w_data_q[7:0] : sp_q[7:0];
					sp_q[15:8] <= w_strb_q[1] ?
						w_data_q[15:8] : sp_q[15:8];
				end
				`CFFC_OFS_ACC: begin
					acc_a_q <= w_strb_q[0] ?
						w_data_q[7:0] : acc_a_q;
					acc_b_q <= w_strb_q[1] ?
						w_data_q[15:8] : acc_b_q;
				end
				`CFFC_OFS_IDX: begin
					idx_x_q <= {w_strb_q[1] ? w_data_q[15:8]
						: idx_x_q[15:8], w_strb_q[0] ?
						w_data_q[7:0] : idx_x_q[7:0]};
					idx_y_q <= {w_strb_q[3] ? w_data_q[31:24]
						: idx_y_q[15:8], w_strb_q[2] ?
						w_data_q[23:16] : idx_y_q[7:0]};
				end
				default: ;	// Read-only targets
				endcase
			end
			case (state_q)
			ST_IDLE: if (start_q) begin
				start_q   <= 1'b0;
				illegal_q <= 1'b0;
				case (op)
				`CFFC_OP_NOP: ;
				// Only C, I and V have set and clear
				`CFFC_OP_CCLR: flags_q[`CFFC_FL_C] <= 1'b0;
				`CFFC_OP_CSET: flags_q[`CFFC_FL_C] <= 1'b1;
				`CFFC_OP_ICLR: flags_q[`CFFC_FL_I] <= 1'b0;
				`CFFC_OP_SEI: flags_q[`CFFC_FL_I] <= 1'b1;
				`CFFC_OP_VCLR: flags_q[`CFFC_FL_V] <= 1'b0;
				`CFFC_OP_VSET: flags_q[`CFFC_FL_V] <= 1'b1;
				// A to flags: S copies A; X may only fall
				`CFFC_OP_TAP: flags_q <= {acc_a_q[7],
					acc_a_q[6] & flags_q[`CFFC_FL_X],
					acc_a_q[5:0]};
				`CFFC_OP_FTOA: acc_a_q <= flags_q;
				`CFFC_OP_BR: begin
					taken_q <= cond_taken;
					if (cond_taken)
						pc_q <= rel_tgt;
				end
				// Bit tests read their byte first
				`CFFC_OP_BTCLR, `CFFC_OP_BTSET: begin
					maddr_q <= ea;
					mre_q   <= 1'b1;
					state_q <= ST_READ;
				end
				`CFFC_OP_JUMP: pc_q <= ea;
				// Calls stack the two-byte resume address
				`CFFC_OP_CALL, `CFFC_OP_RCALL: begin
					tgt_q   <= (op == `CFFC_OP_CALL) ?
						ea : rel_tgt;
					cnt_q   <= 4'h0;
					last_q  <= `CFFC_STK_RET;
					state_q <= ST_PUSH;
				end
				`CFFC_OP_RTS, `CFFC_OP_IRET: begin
					cnt_q   <= (op == `CFFC_OP_RTS) ?
						`CFFC_STK_RET : `CFFC_STK_ALL;
					vec_q   <= 1'b0;
					state_q <= ST_PULLA;
				end
				// Full frame before the vector or standby
				`CFFC_OP_SINT, `CFFC_OP_WAIT: begin
					cnt_q   <= 4'h0;
					last_q  <= `CFFC_STK_ALL;
					state_q <= ST_PUSH;
				end
				// Stop-disable set turns stop into a no-op
				`CFFC_OP_STOP:
					if (!flags_q[`CFFC_FL_S])
						state_q <= ST_STOP;
				default: illegal_q <= 1'b1;
				endcase
			end
			ST_READ: begin
				taken_q <= (tst == 8'h00);
				if (tst == 8'h00)
					pc_q <= rel_tgt;
				state_q <= ST_IDLE;
			end
			// Write at SP, then step down to the next free byte
			ST_PUSH: begin
				maddr_q  <= sp_q;
				mwdata_q <= push_byte;
				mwe_q    <= 1'b1;
				sp_q     <= sp_q - 16'h0001;
				if (cnt_q != last_q)
					cnt_q <= cnt_q + 4'h1;
				else if (op == `CFFC_OP_WAIT)
					state_q <= ST_WAIT;
				else if (op == `CFFC_OP_SINT) begin
					flags_q[`CFFC_FL_I] <= 1'b1;
					vaddr_q <= `CFFC_VEC_SINT;
					vec_q   <= 1'b1;
					cnt_q   <= 4'h1;
					state_q <= ST_PULLA;
				end else begin
					pc_q    <= tgt_q;
					state_q <= ST_IDLE;
				end
			end
			// Pull steps up first; vectors read high byte first
			ST_PULLA: begin
				mre_q   <= 1'b1;
				state_q <= ST_PULLD;
				if (vec_q)
					maddr_q <= vaddr_q + {15'h0000, ~cnt_q[0]};
				else begin
					maddr_q <= sp_q + 16'h0001;
					sp_q    <= sp_q + 16'h0001;
				end
			end
			ST_PULLD: begin
				case (cnt_q)
				4'h0: pc_q[7:0]     <= mem_rdata;
				4'h1: pc_q[15:8]    <= mem_rdata;
				4'h2: idx_y_q[7:0]  <= mem_rdata;
				4'h3: idx_y_q[15:8] <= mem_rdata;
				4'h4: idx_x_q[7:0]  <= mem_rdata;
				4'h5: idx_x_q[15:8] <= mem_rdata;
				4'h6: acc_a_q       <= mem_rdata;
				4'h7: acc_b_q       <= mem_rdata;
				// Restored X can only fall; S is kept
				default: flags_q <= {flags_q[`CFFC_FL_S],
					mem_rdata[6] & flags_q[`CFFC_FL_X],
					mem_rdata[5:0]};
				endcase
				if (cnt_q == 4'h0) begin
					vec_q   <= 1'b0;
					state_q <= ST_IDLE;
				end else begin
					cnt_q   <= cnt_q - 4'h1;
					state_q <= ST_PULLA;
				end
			end
			// Already stacked, so a request goes to the vector
			ST_WAIT: if (nmi_pend || irq_pend) begin
				flags_q[`CFFC_FL_I] <= 1'b1;
				if (nmi_pend)
					flags_q[`CFFC_FL_X] <= 1'b1;
				vaddr_q <= nmi_pend ? `CFFC_VEC_NMI
					: `CFFC_VEC_IRQ;
				vec_q   <= 1'b1;
				cnt_q   <= 4'h1;
				state_q <= ST_PULLA;
			end
			// Any unmasked request wakes; software resumes
			ST_STOP: if (nmi_pend || irq_pend)
				state_q <= ST_IDLE;
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign mem_addr  = maddr_q;
	assign mem_wdata = mwdata_q;
	assign mem_we    = mwe_q;
	assign mem_re    = mre_q;
	assign wait_mode = (state_q == ST_WAIT);
	assign stop_mode = (state_q == ST_STOP);

endmodule // cffc_core

// [test/cffc_mem_model.sv]
// Program and stack memory model for the flag and flow unit
`timescale 1ns/1ps
module cffc_mem_model (
	// Clock
	input  wire        aclk,
	// Memory port
	input  wire [15:0] mem_addr,
	input  wire [7:0]  mem_wdata,
	input  wire        mem_we,
	input  wire        mem_re,
	output wire [7:0]  mem_rdata
);
	logic [7:0] mem [0:65535]; // Byte space
	logic [7:0] last_q = 8'h0;  // Last byte handed out
	// Clear space, then place the three handler vectors
	initial begin
		for (int k = 0; k < 65536; k++)
			mem[k] = 8'h0;
		mem[16'hfff2] = 8'h30;
		mem[16'hfff4] = 8'h60;
		mem[16'hfff6] = 8'h50;
	end
	// Undriven bus shows the inverse, so a stale sample cannot match
	assign mem_rdata = mem_re ? mem[mem_addr] : ~last_q;
	// Write on the strobe, remember the last read
	always @(posedge aclk) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		if (mem_re)
			last_q <= mem[mem_addr];
	end
endmodule // cffc_mem_model

// [test/cffc_core_sva.sv]
// Port checker for the flag and flow unit
`timescale 1ns/1ps
module cffc_core_sva (
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Bus handshakes
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// Memory, requests, power
	input wire [15:0] mem_addr,
	input wire        mem_we,
	input wire        mem_re,
	input wire        irq_in,
	input wire        nonmaskable_irq_input_n,
	input wire        wait_mode,
	input wire        stop_mode
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_wait_holds: assert property (
		wait_mode && !irq_in && nonmaskable_irq_input_n |=> wait_mode)
		else $error("standby left with no request");
	a_wait_vector: assert property (
		$fell(wait_mode) |-> ##[0:6] (mem_re && mem_addr[15:4] == 12'hfff))
		else $error("no vector fetch after wake");
	a_wait_nostack: assert property (
		$fell(wait_mode) |-> !mem_we [*6])
		else $error("stacking after wake");
	a_push_down: assert property (
		mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) - 16'h1)
		else $error("push order broken");
	a_pull_up: assert property (
		mem_re && $past(mem_re, 2) |->
		mem_addr == $past(mem_addr, 2) + 16'h1)
		else $error("pull order broken");
	a_stop_holds: assert property (
		stop_mode && !irq_in && nonmaskable_irq_input_n |=> stop_mode)
		else $error("stop left with no request");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	c_wait: cover property ($fell(wait_mode));
	c_stop: cover property ($fell(stop_mode));
	c_push: cover property (mem_we && $past(mem_we));
endmodule // cffc_core_sva
bind cffc_core cffc_core_sva i_sva (.*);

// [test/tb_top.sv]
// Self-checking bench for the flag and flow unit
`timescale 1ns/1ps
`include "cffc_consts.vh"
module tb_top;
	// ****************************************
	// Signals and tables
	// ****************************************
	logic        aclk = 1'h0, aresetn = 1'h0, irq_in = 1'h0;
	logic        nonmaskable_irq_input_n = 1'h1;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h1;
	logic        s_axi_rready = 1'h1;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid, mem_we, mem_re;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [15:0] mem_addr;
	wire  [7:0]  mem_wdata, mem_rdata, o_fl = `CFFC_OFS_FLAGS;
	wire  [7:0]  o_pc = `CFFC_OFS_PC, o_sp = `CFFC_OFS_SP;
	wire  [7:0]  o_ac = `CFFC_OFS_ACC, o_st = `CFFC_OFS_STATUS;
	wire         wait_mode, stop_mode;
	int          miscompares = 0, cmp_count = 0;
	// Per condition code: {n,z,v,c flags, taken}
	logic [4:0]  br_row [16] = '{5'h01, 5'h00, 5'h01, 5'h09, 5'h02,
		5'h03, 5'h08, 5'h09, 5'h04, 5'h05, 5'h10, 5'h11, 5'h15, 5'h11,
		5'h08, 5'h05};
	// Stack image after the software interrupt, in push order
	logic [7:0]  stk [9] = '{8'h34, 8'h12, 8'h66, 8'h55, 8'h88, 8'h77,
		8'hcd, 8'hab, 8'hbf};

	always #25 aclk = ~aclk;
	cffc_core i_cffc_core (.*);
	cffc_mem_model i_cffc_mem_model (.*);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_sim();
		$display("checks %0d bad %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic guard(int n);
		if (n >= 60) begin
			miscompares++;
			end_sim();
		end
	endtask
	task automatic chk(string nm, logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// Bus write; valids drop at the edge that takes them
	task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
		int n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 60);
		guard(n);
		r = s_axi_bresp;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d, logic [1:0] r);
		int n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 60);
		guard(n);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic ck(logic [7:0] a, logic [31:0] m, e, string nm);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, e, d & m);
	endtask
	// Start an operation: operand write, then instruction write
	task automatic go(logic [31:0] o, i);
		logic [1:0] r;
		wr(`CFFC_OFS_OPND, o, r);
		wr(`CFFC_OFS_INSTR, i, r);
	endtask
	task automatic idle();
		logic [31:0] d;
		logic [1:0]  r;
		int n = 0;
		do begin
			rd(o_st, d, r);
			n++;
		end while (d[0] !== 1'h0 && n < 60);
		guard(n);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		ck(o_fl, 32'hff, 32'hd0, "flags rst");
		ck(o_sp, 32'hffff, 32'hff, "sp rst");
		rd(8'h40, d, r);
		chk("unmapped rd", 32'h2, r);
		wr(8'h40, 32'h0, r);
		chk("unmapped wr", 32'h2, r);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			wr(o_ac, {28'h00f, br_row[i][4:1]}, r);
			go(32'h0, `CFFC_OP_TAP);
			idle();
			wr(o_pc, 32'h1000, r);
			go(32'h80, {20'h0, i[3:0], 3'h0, `CFFC_OP_BR});
			idle();
			ck(o_st, 32'h8, {br_row[i][0], 3'h0}, "taken");
			ck(o_pc, 32'hffff, br_row[i][0] ? 32'hf80 : 32'h1000,
				"br pc");
		end
		$display("test branches done");
		foreach (stk[k]) begin
			if (k < 6) begin
				d = k < 2 ? 32'h1 : k < 4 ? 32'h10 : 32'h2;
				go(32'h0, k[4:0] + 5'h1);
				idle();
				ck(o_fl, d, k[0] ? d : 32'h0, "flag op");
			end
		end
		go(32'h0, `CFFC_OP_FTOA);
		idle();
		ck(o_ac, 32'hff, 32'hf3, "flags to a");
		wr(o_ac, 32'h0, r);
		go(32'h0, `CFFC_OP_TAP);
		idle();
		ck(o_fl, 32'hff, 32'h0, "a to flags");
		go(32'h0, `CFFC_OP_STOP);
		repeat (4) @(posedge aclk);
		chk("stop on", 32'h1, stop_mode);
		irq_in <= 1'h1;
		idle();
		irq_in <= 1'h0;
		wr(o_ac, 32'hff, r);
		go(32'h0, `CFFC_OP_TAP);
		idle();
		ck(o_fl, 32'hff, 32'hbf, "mask x");
		go(32'h0, `CFFC_OP_STOP);
		idle();
		chk("stop off", 32'h0, stop_mode);
		$display("test flags done");
		go(32'h1234, {25'h0, `CFFC_MD_EXT, `CFFC_OP_JUMP});
		idle();
		go(32'h4000, {25'h0, `CFFC_MD_EXT, `CFFC_OP_CALL});
		idle();
		chk("ret lo", 32'h34, i_cffc_mem_model.mem[16'hff]);
		ck(o_sp, 32'hffff, 32'hfd, "jsr sp");
		ck(o_pc, 32'hffff, 32'h4000, "jsr pc");
		go(32'h0, `CFFC_OP_RTS);
		idle();
		ck(o_pc, 32'hffff, 32'h1234, "rts pc");
		wr(`CFFC_OFS_IDX, 32'h55667788, r);
		wr(o_ac, 32'habcd, r);
		go(32'h0, `CFFC_OP_SINT);
		idle();
		foreach (stk[k])
			chk("swi stack", stk[k], i_cffc_mem_model.mem[8'hff - k]);
		ck(o_pc, 32'hffff, 32'h5000, "swi pc");
		go(32'h0, `CFFC_OP_IRET);
		idle();
		ck(o_sp, 32'hffff, 32'hff, "rti sp");
		$display("test calls done");
		go(32'h0, `CFFC_OP_WAIT);
		n = 0;
		while (wait_mode !== 1'h1 && n < 60) begin
			@(posedge aclk);
			n++;
		end
		guard(n);
		repeat (10) @(posedge aclk);
		chk("standby", 32'h1, wait_mode);
		nonmaskable_irq_input_n <= 1'h0;
		idle();
		nonmaskable_irq_input_n <= 1'h1;
		ck(o_pc, 32'hffff, 32'h6000, "wake pc");
		$display("test wait done");
		end_sim();
	end
endmodule // tb_top
